// [core/drt_pkg.sv]
// shared constants and types for the dram renew request timer
package drt_pkg;

  // interval counter
  localparam int           INTERVAL_WIDTH   = 8;
  localparam int           INTERVAL_MSB     = INTERVAL_WIDTH - 1;
  localparam logic [7:0]   INTERVAL_RESET   = 8'h00;
  localparam logic [7:0]   INTERVAL_STEP    = 8'h01;
  localparam logic [6:0]   HALF_PHASE_START = 7'h00;

  // renew square wave; 256 counter cycles long, so its period follows sys_clk, not the clock the counter was sized for
  localparam int           SYS_CLK_PERIOD_NS      = 10;
  localparam int           SIZING_CLK_PERIOD_NS   = 40;
  localparam int           RENEW_PERIOD_NS        = 10240;
  localparam int           RENEW_PERIOD_CYCLES    = RENEW_PERIOD_NS / SIZING_CLK_PERIOD_NS;
  localparam int           RENEW_HALF_CYCLES      = RENEW_PERIOD_CYCLES / 2;
  localparam int           RENEW_PERIOD_SYS_NS    = RENEW_PERIOD_CYCLES * SYS_CLK_PERIOD_NS;

  // request state machine, encodings fixed by the controller handshake
  typedef enum logic [1:0] {
    DRT_IDLE         = 2'b00,
    DRT_RENEW_ASKING = 2'b01,
    DRT_RENEW_WAIT   = 2'b10
  } drt_state_t;

  // four long word burst read pacing: 14-7-7-7
  localparam int           BURST_WORDS        = 4;
  localparam logic [5:0]   BURST_FIRST_CYCLES = 6'h0e;
  localparam logic [5:0]   BURST_NEXT_CYCLES  = 6'h07;
  localparam logic [5:0]   BURST_TOTAL_CYCLES = 6'h23;
  localparam logic [5:0]   BURST_COUNT_RESET  = 6'h00;
  localparam logic [5:0]   BURST_COUNT_START  = 6'h01;
  localparam logic [5:0]   BURST_COUNT_STEP   = 6'h01;

endpackage : drt_pkg

// [core/drt_interval_counter.sv]
// free running 8-bit renew interval counter
`timescale 1ns/100ps
`default_nettype none
module drt_interval_counter
  import drt_pkg::*;
(
  input  wire logic                            sys_clk,
  input  wire logic                            reset_n,
  output var  logic [drt_pkg::INTERVAL_MSB:0]  interval_count
);

  // plain binary increment, no enable, wraps from ff to 00
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      interval_count <= INTERVAL_RESET;
    else
      interval_count <= interval_count + INTERVAL_STEP;
  end

  a_counter_step : assert property (@(posedge sys_clk) disable iff (!reset_n)
    $past(reset_n) |-> interval_count == 8'($past(interval_count) + INTERVAL_STEP))
    else $error("interval counter did not advance by one");

  // the top bit may only change when the low seven bits have just wrapped
  a_msb_half_phase : assert property (@(posedge sys_clk) disable iff (!reset_n)
    $past(reset_n) && $changed(interval_count[INTERVAL_MSB])
      |-> interval_count[INTERVAL_MSB-1:0] == HALF_PHASE_START)
    else $error("top bit changed away from a half period boundary");

endmodule // drt_interval_counter
`default_nettype wire

// [core/drt_renew_timer.sv]
// renew request timer: interval square wave, renew request handshake, burst read pacing
`timescale 1ns/100ps
`default_nettype none
module drt_renew_timer
  import drt_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  reset_n,
  input  wire logic  renew_cycle_begun,
  input  wire logic  burst_start,
  output var  logic  memory_renew_request,
  output var  logic  interval_msb,
  output var  logic  burst_busy,
  output var  logic  burst_word_ready,
  output var  logic  burst_last_word
);

  logic [INTERVAL_MSB:0]  interval_count;
  drt_state_t             renew_state;
  drt_state_t             next_renew_state;
  logic                   next_memory_renew_request;
  logic [5:0]             burst_count;
  logic                   next_word_edge;
  logic                   next_last_edge;
  logic                   phase_requested;

  drt_interval_counter u_interval_counter
  (
    .sys_clk        (sys_clk),
    .reset_n        (reset_n),
    .interval_count (interval_count)
  );

  // square wave taken straight from the counter flop
  assign interval_msb = interval_count[INTERVAL_MSB];

  // request state machine; the request is registered together with the state
  always_comb
  begin
    next_renew_state          = renew_state;
    next_memory_renew_request = 1'b0;
    unique case (renew_state)
      DRT_IDLE:
      begin
        if (interval_count[INTERVAL_MSB])
        begin
          next_renew_state          = DRT_RENEW_ASKING;
          next_memory_renew_request = 1'b1;
        end
      end
      DRT_RENEW_ASKING:
      begin
        // begun is driven by the sequencer on this same clock, so no synchroniser
        if (renew_cycle_begun)
        begin
          next_renew_state          = DRT_RENEW_WAIT;
          next_memory_renew_request = 1'b0;
        end
        else
        begin
          next_memory_renew_request = 1'b1;
        end
      end
      DRT_RENEW_WAIT:
      begin
        // waiting for the low phase is what stops a second request in the same phase
        if (!interval_count[INTERVAL_MSB])
          next_renew_state = DRT_IDLE;
      end
      default:
      begin
        // code 11 is unused; recover to idle
        next_renew_state = DRT_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      renew_state <= DRT_IDLE;
    else
      renew_state <= next_renew_state;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      memory_renew_request <= 1'b0;
    else
      memory_renew_request <= next_memory_renew_request;
  end

  // burst pacing: word edges fall on clocks 14, 21, 28 and 35 after the start
  always_comb
  begin
    next_word_edge = 1'b0;
    for (int w = 0; w < BURST_WORDS; w++)
    begin
      if (burst_count == 6'(BURST_FIRST_CYCLES + 6'(w) * BURST_NEXT_CYCLES - BURST_COUNT_STEP))
        next_word_edge = burst_busy;
    end
    next_last_edge = burst_busy && (burst_count == 6'(BURST_TOTAL_CYCLES - BURST_COUNT_STEP));
  end

  // a start during a running burst is ignored; the pacing is not restartable mid-burst
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      burst_count <= BURST_COUNT_RESET;
    else if (!burst_busy && burst_start)
      burst_count <= BURST_COUNT_START;
    else if (burst_busy)
      burst_count <= burst_count + BURST_COUNT_STEP;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      burst_busy <= 1'b0;
    else if (!burst_busy && burst_start)
      burst_busy <= 1'b1;
    else if (next_last_edge)
      burst_busy <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      burst_word_ready <= 1'b0;
      burst_last_word  <= 1'b0;
    end
    else
    begin
      burst_word_ready <= next_word_edge;
      burst_last_word  <= next_last_edge;
    end
  end

  // remembers that the current high phase has already produced its request;
  // only the checker reads it, so it costs nothing once assertions are stripped
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      phase_requested <= 1'b0;
    else if (!interval_count[INTERVAL_MSB])
      phase_requested <= 1'b0;
    else if (memory_renew_request)
      phase_requested <= 1'b1;
  end

  a_state_legal : assert property (@(posedge sys_clk) disable iff (!reset_n)
    renew_state inside {2'b00, 2'b01, 2'b10})
    else $error("request state left its three legal codes");

  a_idle_raise : assert property (@(posedge sys_clk) disable iff (!reset_n)
    renew_state == DRT_IDLE && interval_count[INTERVAL_MSB]
      |=> renew_state == DRT_RENEW_ASKING && memory_renew_request)
    else $error("idle did not raise the request on a high top bit");

  a_idle_quiet : assert property (@(posedge sys_clk) disable iff (!reset_n)
    renew_state == DRT_IDLE && !interval_count[INTERVAL_MSB]
      |=> renew_state == DRT_IDLE && !memory_renew_request)
    else $error("idle left or raised the request on a low top bit");

  a_ask_hold : assert property (@(posedge sys_clk) disable iff (!reset_n)
    renew_state == DRT_RENEW_ASKING && !renew_cycle_begun
      |=> renew_state == DRT_RENEW_ASKING && memory_renew_request)
    else $error("request dropped before renew begun");

  a_ask_drop : assert property (@(posedge sys_clk) disable iff (!reset_n)
    renew_state == DRT_RENEW_ASKING && renew_cycle_begun
      |=> renew_state == DRT_RENEW_WAIT && !memory_renew_request)
    else $error("renew begun did not end the request");

  a_wait_hold : assert property (@(posedge sys_clk) disable iff (!reset_n)
    renew_state == DRT_RENEW_WAIT && interval_count[INTERVAL_MSB]
      |=> renew_state == DRT_RENEW_WAIT && !memory_renew_request)
    else $error("wait state left during the high phase");

  a_wait_exit : assert property (@(posedge sys_clk) disable iff (!reset_n)
    renew_state == DRT_RENEW_WAIT && !interval_count[INTERVAL_MSB]
      |=> renew_state == DRT_IDLE && !memory_renew_request)
    else $error("wait state did not return to idle on the low phase");

  a_single_request : assert property (@(posedge sys_clk) disable iff (!reset_n)
    phase_requested |-> !$rose(memory_renew_request))
    else $error("second request raised in one high phase");

  a_reset_idle : assert property (@(posedge sys_clk)
    !reset_n |=> renew_state == DRT_IDLE && !memory_renew_request && interval_count == 8'h00)
    else $error("reset did not clear the request machine");

  a_burst_pacing : assert property (@(posedge sys_clk) disable iff (!reset_n)
    !burst_busy && burst_start
      |=> !burst_word_ready [*7] ##1 !burst_word_ready [*6] ##1 burst_word_ready ##7 burst_word_ready
          ##7 burst_word_ready ##7 (burst_word_ready && burst_last_word))
    else $error("burst words not paced fourteen seven seven seven");

  a_start_ignored : assert property (@(posedge sys_clk) disable iff (!reset_n)
    burst_busy && burst_start && !next_last_edge
      |=> burst_busy && burst_count == 6'($past(burst_count) + BURST_COUNT_STEP))
    else $error("start during a burst disturbed the pacing");

  a_burst_busy_span : assert property (@(posedge sys_clk) disable iff (!reset_n)
    !burst_busy && burst_start |=> burst_busy ##34 !burst_busy)
    else $error("burst did not span thirty five clocks");

endmodule // drt_renew_timer
`default_nettype wire

// [tb/drt_seq_model.sv]
// behavioural ras/cas sequencer that answers renew requests
`timescale 1ns/100ps
`default_nettype none
module drt_seq_model
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        memory_renew_request,
  input  wire logic [7:0]  answer_delay,
  output var  logic        renew_cycle_begun
);
  logic [7:0] wait_count;

  // a one-cycle pulse; a request still high afterwards restarts the count and is answered again
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      wait_count        <= 8'h00;
      renew_cycle_begun <= 1'b0;
    end
    else if (memory_renew_request && !renew_cycle_begun)
    begin
      wait_count        <= wait_count + 8'h01;
      renew_cycle_begun <= (wait_count == answer_delay);
    end
    else
    begin
      wait_count        <= 8'h00;
      renew_cycle_begun <= 1'b0;
    end
  end
endmodule // drt_seq_model
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the renew request timer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import drt_pkg::*;
  logic       sys_clk     = 1'b0;
  logic       reset_n     = 1'b0;
  logic       burst_start = 1'b0;
  logic [7:0] seq_delay   = 8'h00;
  logic       begun, req, msb, busy, word, last;
  int         n_mismatch  = 0;
  int         samples_checked = 0;

  always #5 sys_clk = ~sys_clk;

  drt_renew_timer i_drt_renew_timer (.sys_clk(sys_clk), .reset_n(reset_n), .renew_cycle_begun(begun),
    .burst_start(burst_start), .memory_renew_request(req), .interval_msb(msb), .burst_busy(busy),
    .burst_word_ready(word), .burst_last_word(last));
  drt_seq_model i_drt_seq_model (.sys_clk(sys_clk), .reset_n(reset_n), .memory_renew_request(req),
    .answer_delay(seq_delay), .renew_cycle_begun(begun));

  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  // bounded so a stuck square wave ends the test instead of hanging it
  task automatic wait_msb(input logic v);
    int n;
    n = 0;
    while (msb !== v && n < 300)
    begin
      tick();
      n++;
    end
  endtask

  task automatic t_wave();
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    wait_msb(1'b0);
    wait_msb(1'b1);
    while (msb === 1'b1 && hi < 300)
    begin
      tick();
      hi++;
    end
    while (msb === 1'b0 && lo < 300)
    begin
      tick();
      lo++;
    end
    check(9'(hi), 9'(RENEW_HALF_CYCLES), "high phase");
    check(9'(lo), 9'(RENEW_HALF_CYCLES), "low phase");
    $display("wave test done");
  endtask

  task automatic t_renew(input logic [7:0] d);
    int   n;
    logic was;
    n = 0;
    was = 1'b0;
    @(posedge sys_clk);
    seq_delay <= d;
    #1;
    wait_msb(1'b0);
    wait_msb(1'b1);
    check(req, 1'b0, "request early");
    tick();
    check(req, 1'b1, "request raised");
    while (req === 1'b1 && n < 400)
    begin
      was = begun;
      tick();
      n++;
    end
    check(was, 1'b1, "drop without begun");
    check(9'(n), 9'(d) + 9'h002, "request hold");
    while (msb === 1'b1 && n < 400)
    begin
      check(req, 1'b0, "second request");
      tick();
      n++;
    end
    $display("renew test done");
  endtask

  task automatic t_burst();
    @(posedge sys_clk);
    burst_start <= 1'b1;
    @(posedge sys_clk);
    burst_start <= 1'b0;
    for (int k = 1; k <= 40; k++)
    begin
      @(posedge sys_clk);
      burst_start <= (k == 5);
      #1;
      // the value seen just after edge k is the one that stands through clock k+1
      check(word, (k == 13 || k == 20 || k == 27 || k == 34), "word ready");
      check(last, (k == 34), "last word");
      check(busy, (k < 34), "busy");
    end
    $display("burst test done");
  endtask

  task automatic t_reset();
    @(posedge sys_clk);
    seq_delay <= 8'hc8;
    #1;
    wait_msb(1'b0);
    wait_msb(1'b1);
    tick();
    // the long answer delay keeps this request pending when reset arrives
    check(req, 1'b1, "request before reset");
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) tick();
    check(req, 1'b0, "request in reset");
    check(msb, 1'b0, "wave in reset");
    check(busy, 1'b0, "busy in reset");
    @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) tick();
    check(req, 1'b0, "request after reset");
    check(msb, 1'b0, "wave after reset");
    $display("reset test done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_wave();
    t_renew(8'h01);
    t_renew(8'h8c);
    t_renew(8'h00);
    t_burst();
    t_reset();
    final_report();
  end

  initial
  begin
    repeat (8000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire
